// ---- pkg/jump_inc_pkg.sv ----
// constants for the jump and increment execution block
// assumes a core that feeds one 14-bit instruction word per instruction cycle
package jump_inc_pkg;
  // ==========================================================================
  // widths
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int LIT_W = 11;
  localparam int PHASES = 4;
  // ==========================================================================
  // instruction encodings
  localparam logic [2:0] JUMP_OP = 3'h5;        // bits 13:11
  localparam logic [5:0] INCREMENT_FILE_REGISTER_OP = 6'h0A;       // bits 13:8
  localparam int OP_JUMP_LSB = 11;
  localparam int OP_INC_LSB = 8;
  localparam int DEST_BIT = 7;
  // ==========================================================================
  // latch field feeding the upper program counter bits
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;
  // ==========================================================================
  // reset values and phase numbers
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [1:0] PHASE_DECODE = 2'h0;
  localparam logic [1:0] PHASE_WRITE = 2'h3;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  // ==========================================================================
  // execution states
  typedef enum logic [1:0] {EXEC_ST, FLUSH_ST} exec_state_t;
endpackage : jump_inc_pkg

// ---- rtl/incrementer.sv ----
// increment unit: adds one to a file register value and flags a zero result
// assumes the operand is stable from the read phase to the write phase
`timescale 1ns/1ps
module incrementer (
  input wire logic [7:0] operand,
  output logic [7:0] sum,
  output logic is_zero
);
  // ==========================================================================
  // adder; carry out deliberately dropped, wraps 0xFF to 0x00
  always_comb begin
    sum = operand + jump_inc_pkg::ONE;
    is_zero = (sum == jump_inc_pkg::DATA_RESET);
  end
endmodule : incrementer

// ---- rtl/jump_and_increment_exec.sv ----
// execution of the unconditional jump and the file register increment
// assumes fetch supplies instr on phase 0 and the file register file is external
`timescale 1ns/1ps
// Summary of operation
// - jump copies eleven-bit literal into program counter bits 10 to 0
// - jump fills program counter bits 12 and 11 from latch bits 4 and 3
// - jump takes two cycles; second cycle is a no-operation flush
// - increment reads addressed file register, adds one, finishes in one cycle
// - destination bit 0 writes result to working register only
// - destination bit 1 writes result back into the addressed file register
module jump_and_increment_exec (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [7:0] program_counter_high_latch,
  input wire logic [7:0] file_rdata,
  output logic [6:0] file_addr,
  output logic [7:0] file_wdata,
  output logic file_we,
  output logic [7:0] w_reg,
  output logic zero_flag_reg,
  output logic [12:0] pc_reg,
  output logic pc_load,
  output logic flush,
  output logic [1:0] phase_reg
);
  jump_inc_pkg::exec_state_t state_reg;
  logic [13:0] ir_reg;
  logic [7:0] inc_sum;
  logic inc_zero;
  logic is_jump;
  logic is_inc;
  logic at_decode;
  logic at_write;
  logic [7:0] file_wdata_next;

  // ==========================================================================
  // decode
  assign at_decode = (phase_reg == jump_inc_pkg::PHASE_DECODE);
  assign at_write = (phase_reg == jump_inc_pkg::PHASE_WRITE);
  assign is_jump = (state_reg == jump_inc_pkg::EXEC_ST) &&
                   (ir_reg[jump_inc_pkg::INSTR_W-1:jump_inc_pkg::OP_JUMP_LSB] == jump_inc_pkg::JUMP_OP);
  assign is_inc = (state_reg == jump_inc_pkg::EXEC_ST) &&
                  (ir_reg[jump_inc_pkg::INSTR_W-1:jump_inc_pkg::OP_INC_LSB] == jump_inc_pkg::INCREMENT_FILE_REGISTER_OP);
  assign file_addr = ir_reg[jump_inc_pkg::FADDR_W-1:0];
  assign file_wdata_next = inc_sum;
  assign flush = (state_reg == jump_inc_pkg::FLUSH_ST);

  incrementer u_inc (
    .operand(file_rdata),
    .sum(inc_sum),
    .is_zero(inc_zero)
  );

  // ==========================================================================
  // four-phase instruction cycle counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= jump_inc_pkg::PHASE_DECODE;
    end else if (clk_en) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // instruction register; an empty slot decodes as no operation
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_reg <= 14'h0000;
    end else if (clk_en && at_decode) begin
      ir_reg <= instr_valid ? instr : 14'h0000;
    end
  end

  // ==========================================================================
  // jump: second cycle discards the prefetched word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= jump_inc_pkg::EXEC_ST;
    end else if (clk_en && at_write) begin
      case (state_reg)
        jump_inc_pkg::EXEC_ST: begin
          if (is_jump) begin
            state_reg <= jump_inc_pkg::FLUSH_ST;
          end
        end
        jump_inc_pkg::FLUSH_ST: state_reg <= jump_inc_pkg::EXEC_ST;
        default: state_reg <= jump_inc_pkg::EXEC_ST;
      endcase
    end
  end

  // program counter load on the write phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= jump_inc_pkg::PC_RESET;
      pc_load <= 1'b0;
    end else if (clk_en) begin
      pc_load <= 1'b0;
      if (at_write && is_jump) begin
        pc_reg <= {program_counter_high_latch[jump_inc_pkg::LATCH_HI:jump_inc_pkg::LATCH_LO],
                   ir_reg[jump_inc_pkg::LIT_W-1:0]};
        pc_load <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // increment result: write phase only, single cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_reg <= jump_inc_pkg::DATA_RESET;
      file_wdata <= jump_inc_pkg::DATA_RESET;
      file_we <= 1'b0;
    end else if (clk_en) begin
      file_we <= 1'b0;
      if (at_write && is_inc) begin
        if (ir_reg[jump_inc_pkg::DEST_BIT]) begin
          file_wdata <= file_wdata_next;
          file_we <= 1'b1;
        end else begin
          w_reg <= inc_sum;
        end
      end
    end
  end

  // zero flag; jump never touches it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_flag_reg <= 1'b0;
    end else if (clk_en && at_write && is_inc) begin
      zero_flag_reg <= inc_zero;
    end
  end

  // ==========================================================================
  // checks
  property p_jump_pc;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && at_write && is_jump) |=> (pc_load && pc_reg[10:0] == $past(ir_reg[10:0]));
  endproperty
  a_jump_pc: assert property (p_jump_pc) else $error("jump literal not loaded");

  property p_jump_hi;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && at_write && is_jump) |=> (pc_reg[12:11] == $past(program_counter_high_latch[4:3]));
  endproperty
  a_jump_hi: assert property (p_jump_hi) else $error("upper pc bits wrong");

  property p_flush;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && at_write && is_jump) |=> flush;
  endproperty
  a_flush: assert property (p_flush) else $error("no flush cycle after jump");

  property p_inc_dest1;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && at_write && is_inc && ir_reg[7]) |=> (file_we && file_wdata == $past(file_rdata) + 8'h01);
  endproperty
  a_inc_dest1: assert property (p_inc_dest1) else $error("file write-back wrong");

  property p_inc_dest0;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && at_write && is_inc && !ir_reg[7]) |=> (!file_we && w_reg == $past(file_rdata) + 8'h01);
  endproperty
  a_inc_dest0: assert property (p_inc_dest0) else $error("working register write wrong");

  property p_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && at_write && is_inc) |=> (zero_flag_reg == ($past(file_rdata) == 8'hFF));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_jump_keeps_z;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && is_jump) |=> $stable(zero_flag_reg);
  endproperty
  a_jump_keeps_z: assert property (p_jump_keeps_z) else $error("jump changed zero flag");

  // a frozen enable legally stretches the strobe, so only enabled clocks count
  property p_we_single;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && file_we) |=> !file_we;
  endproperty
  a_we_single: assert property (p_we_single) else $error("write strobe longer than one clock");

  // ==========================================================================
  // flush slot, hold and freeze checks
  // the word fetched behind a jump must not write a file register, load the pc, or change w or the zero flag
  property p_flush_discard;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && at_write && flush) |=> (!file_we && !pc_load && $stable(w_reg) && $stable(zero_flag_reg));
  endproperty
  a_flush_discard: assert property (p_flush_discard) else $error("flushed word was executed");

  property p_flush_ends;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && at_write && flush) |=> !flush;
  endproperty
  a_flush_ends: assert property (p_flush_ends) else $error("flush longer than one cycle");

  property p_jump_no_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && at_write && is_jump) |=> !file_we;
  endproperty
  a_jump_no_write: assert property (p_jump_no_write) else $error("jump wrote a file register");

  // program counter moves only on a jump's write phase
  property p_pc_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    !(clk_en && at_write && is_jump) |=> $stable(pc_reg);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc changed without a jump");

  property p_dest1_keeps_w;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en && at_write && is_inc && ir_reg[jump_inc_pkg::DEST_BIT]) |=> $stable(w_reg);
  endproperty
  a_dest1_keeps_w: assert property (p_dest1_keeps_w) else $error("write-back also changed w");

  // low enable must hold the cycle timing where it is
  property p_freeze;
    @(posedge sys_clk) disable iff (!rst_n)
    !clk_en |=> ($stable(phase_reg) && $stable(pc_reg) && $stable(w_reg));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");
endmodule : jump_and_increment_exec

// ---- dv/tb.sv ----
// self-checking bench for the jump and increment execution block
// assumes one word is decoded every four enabled clocks and the file read is combinational
`timescale 1ns/1ps
module tb;
  logic sys_clk, rst_n, clk_en, instr_valid, file_we, zero_flag_reg, pc_load, flush;
  logic [13:0] instr;
  logic [7:0] program_counter_high_latch, file_rdata, file_wdata, w_reg, wd;
  logic [6:0] file_addr, fa;
  logic [12:0] pc_reg, pc_seen;
  logic [1:0] phase_reg;
  int err_total, check_count, we_n, ld_n;
  jump_and_increment_exec i_jump_and_increment_exec (.sys_clk, .rst_n, .clk_en, .instr_valid, .instr,
    .program_counter_high_latch, .file_rdata, .file_addr, .file_wdata, .file_we, .w_reg, .zero_flag_reg,
    .pc_reg, .pc_load, .flush, .phase_reg);
  // =========================================================================
  // clock, 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one word in a slot; pulses are caught over the whole slot, not at a guessed edge
  task automatic issue(input logic [13:0] iw, input logic [7:0] rd);
    int n;
    n = 0;
    while (phase_reg !== 2'h0 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    instr = iw;
    instr_valid = 1'b1;
    file_rdata = rd;
    we_n = 0;
    ld_n = 0;
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      instr_valid = 1'b0;
      if (i == 1) fa = file_addr;
      if (file_we === 1'b1) begin
        we_n++;
        wd = file_wdata;
      end
      if (pc_load === 1'b1) begin
        ld_n++;
        pc_seen = pc_reg;
      end
    end
  endtask : issue
  task automatic t_inc_w;
    issue({jump_inc_pkg::INCREMENT_FILE_REGISTER_OP, 1'b0, 7'h15}, 8'h3C);
    chk("file_addr", {9'h000, fa}, 16'h0015);
    chk("w_reg", {8'h00, w_reg}, 16'h003D);
    chk("file_we count", we_n[15:0], 16'h0000);
    chk("zero", {15'h0000, zero_flag_reg}, 16'h0000);
  endtask : t_inc_w
  // wrap from FF is the boundary that must raise zero
  task automatic t_inc_f;
    issue({jump_inc_pkg::INCREMENT_FILE_REGISTER_OP, 1'b1, 7'h6B}, 8'hFF);
    chk("file_addr", {9'h000, fa}, 16'h006B);
    chk("file_we count", we_n[15:0], 16'h0001);
    chk("file_wdata", {8'h00, wd}, 16'h0000);
    chk("w_reg", {8'h00, w_reg}, 16'h003D);
    chk("zero", {15'h0000, zero_flag_reg}, 16'h0001);
  endtask : t_inc_f
  // the increment sent right behind the jump lands in the flush slot
  task automatic t_jump;
    issue({jump_inc_pkg::JUMP_OP, 11'h5A3}, 8'h00);
    chk("pc_load count", ld_n[15:0], 16'h0001);
    chk("pc low", {5'h00, pc_seen[10:0]}, 16'h05A3);
    chk("pc high", {14'h0000, pc_seen[12:11]}, 16'h0002);
    chk("zero", {15'h0000, zero_flag_reg}, 16'h0001);
    chk("flush", {15'h0000, flush}, 16'h0001);
    issue({jump_inc_pkg::INCREMENT_FILE_REGISTER_OP, 1'b0, 7'h22}, 8'h10);
    chk("file_we count", we_n[15:0], 16'h0000);
    chk("w_reg", {8'h00, w_reg}, 16'h003D);
    chk("pc_reg", {3'h0, pc_reg}, 16'h15A3);
    chk("flush", {15'h0000, flush}, 16'h0000);
    issue({jump_inc_pkg::INCREMENT_FILE_REGISTER_OP, 1'b0, 7'h01}, 8'h7F);
    chk("w_reg", {8'h00, w_reg}, 16'h0080);
    chk("zero", {15'h0000, zero_flag_reg}, 16'h0000);
  endtask : t_jump
  // enable held low mid-slot: nothing may move until it returns
  task automatic t_hold;
    instr = {jump_inc_pkg::INCREMENT_FILE_REGISTER_OP, 1'b0, 7'h0C};
    instr_valid = 1'b1;
    file_rdata = 8'h41;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    clk_en = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("frozen phase", {14'h0000, phase_reg}, 16'h0001);
    chk("frozen w_reg", {8'h00, w_reg}, 16'h0080);
    clk_en = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("phase after hold", {14'h0000, phase_reg}, 16'h0000);
    chk("w_reg after hold", {8'h00, w_reg}, 16'h0042);
  endtask : t_hold
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // =========================================================================
  // main sequence; latch bits other than 4:3 are set, except bit 1, to catch a wrong slice
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    instr_valid = 1'b0;
    instr = 14'h0000;
    program_counter_high_latch = 8'hF5;
    file_rdata = 8'h00;
    err_total = 0;
    check_count = 0;
    repeat (6) @(negedge sys_clk);
    chk("pc in reset", {3'h0, pc_reg}, 16'h0000);
    rst_n = 1'b1;
    t_inc_w;
    t_inc_f;
    t_jump;
    t_hold;
    end_of_test;
  end
  // watchdog, far beyond the few dozen clocks the run needs
  initial begin
    #20000;
    err_total++;
    end_of_test;
  end
endmodule : tb
